// [hw/tmr_wave_ctrl.v]
`timescale 1ns/10ps
`include "tmr_consts.vh"

module tmr_wave_ctrl (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Avalon-MM slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Timer tick qualifier
  input wire timer_tick_enable,
  // Pins
  output reg pin_a_out,
  output reg pin_a_oe,
  output reg pin_b_out,
  output reg pin_b_oe,
  // Interrupt
  output reg irq
);

  reg [7:0] timer_control_a_r;
  reg [7:0] timer_control_b_r;
  reg [15:0] cmp_buf_a_r;
  reg [15:0] cmp_buf_b_r;
  reg [15:0] capture_value_r;
  reg [3:0] port_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg [2:0] irq_stat_nxt;
  reg [31:0] rd_nxt;

  wire req;
  wire wr_en;
  wire [3:0] waveform_mode_sel;
  wire [1:0] chan_a_output_action;
  wire [1:0] chan_b_output_action;
  wire [15:0] counter_value;
  wire count_down;
  wire [15:0] compare_value_a;
  wire [15:0] compare_value_b;
  wire match_a;
  wire match_b;
  wire wave_out_a;
  wire wave_out_b;
  wire wave_on_a;
  wire wave_on_b;
  wire cnt_load;
  wire tick;
  wire at_top;
  wire at_bot;
  wire at_max;
  wire reload;
  wire overflow_flag_set;
  wire [2:0] irq_set;
  wire [2:0] irq_clr;

  reg [1:0] cls;
  reg [1:0] top_src;
  reg [15:0] top_fixed;
  reg [1:0] upd_at;
  reg [1:0] ovf_at;
  reg toggle_ok;
  reg [15:0] top_val;
  reg ovf_evt;
  reg upd_evt;

  // Bus handshake: one wait cycle, then the access completes
  assign req = avs_read | avs_write;
  assign wr_en = avs_write & ~avs_waitrequest;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `TMR_RST32;
    end
    else
    begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
        avs_readdata <= rd_nxt;
    end
  end

  // Four-bit mode is split over both control registers
  assign waveform_mode_sel = {timer_control_b_r[`TMR_CB_MODE_HI:`TMR_CB_MODE_LO],
    timer_control_a_r[`TMR_CA_MODE_HI:`TMR_CA_MODE_LO]};
  assign chan_a_output_action = timer_control_a_r[`TMR_CA_ACT_A_HI:`TMR_CA_ACT_A_LO];
  assign chan_b_output_action = timer_control_a_r[`TMR_CA_ACT_B_HI:`TMR_CA_ACT_B_LO];

  // Mode decode
  always @*
  begin
    cls = `TMR_CLS_NORM;
    top_src = `TMR_TOP_FIX;
    top_fixed = `TMR_MAX;
    upd_at = `TMR_EVT_IMM;
    ovf_at = `TMR_EVT_IMM;
    toggle_ok = 1'b0;
    case (waveform_mode_sel)
      `TMR_MODE_0:
      begin
        top_fixed = `TMR_MAX;
      end
      `TMR_MODE_1, `TMR_MODE_2, `TMR_MODE_3:
      begin
        cls = `TMR_CLS_DUAL;
        upd_at = `TMR_EVT_TOP;
        ovf_at = `TMR_EVT_BOT;
        if (waveform_mode_sel == `TMR_MODE_1)
          top_fixed = `TMR_TOP_8;
        else if (waveform_mode_sel == `TMR_MODE_2)
          top_fixed = `TMR_TOP_9;
        else
          top_fixed = `TMR_TOP_10;
      end
      `TMR_MODE_4:
      begin
        top_src = `TMR_TOP_CMPA;
      end
      `TMR_MODE_5, `TMR_MODE_6, `TMR_MODE_7:
      begin
        cls = `TMR_CLS_FAST;
        upd_at = `TMR_EVT_BOT;
        ovf_at = `TMR_EVT_TOP;
        if (waveform_mode_sel == `TMR_MODE_5)
          top_fixed = `TMR_TOP_8;
        else if (waveform_mode_sel == `TMR_MODE_6)
          top_fixed = `TMR_TOP_9;
        else
          top_fixed = `TMR_TOP_10;
      end
      `TMR_MODE_8:
      begin
        cls = `TMR_CLS_DUAL;
        top_src = `TMR_TOP_CAPT;
        upd_at = `TMR_EVT_BOT;
        ovf_at = `TMR_EVT_BOT;
      end
      `TMR_MODE_9:
      begin
        cls = `TMR_CLS_DUAL;
        top_src = `TMR_TOP_CMPA;
        upd_at = `TMR_EVT_BOT;
        ovf_at = `TMR_EVT_BOT;
        toggle_ok = 1'b1;
      end
      `TMR_MODE_10:
      begin
        cls = `TMR_CLS_DUAL;
        top_src = `TMR_TOP_CAPT;
        upd_at = `TMR_EVT_TOP;
        ovf_at = `TMR_EVT_BOT;
      end
      `TMR_MODE_11:
      begin
        cls = `TMR_CLS_DUAL;
        top_src = `TMR_TOP_CMPA;
        upd_at = `TMR_EVT_TOP;
        ovf_at = `TMR_EVT_BOT;
        toggle_ok = 1'b1;
      end
      `TMR_MODE_12:
      begin
        top_src = `TMR_TOP_CAPT;
      end
      `TMR_MODE_14:
      begin
        cls = `TMR_CLS_FAST;
        top_src = `TMR_TOP_CAPT;
        upd_at = `TMR_EVT_BOT;
        ovf_at = `TMR_EVT_TOP;
        toggle_ok = 1'b1;
      end
      `TMR_MODE_15:
      begin
        cls = `TMR_CLS_FAST;
        top_src = `TMR_TOP_CMPA;
        upd_at = `TMR_EVT_BOT;
        ovf_at = `TMR_EVT_TOP;
        toggle_ok = 1'b1;
      end
      // Reserved mode behaves as a free counter with no PWM
      default:
      begin
        cls = `TMR_CLS_NORM;
      end
    endcase
  end

  // TOP select; compare A as TOP uses the active, not the buffered, value
  always @*
  begin
    case (top_src)
      `TMR_TOP_CMPA: top_val = compare_value_a;
      `TMR_TOP_CAPT: top_val = capture_value_r;
      default: top_val = top_fixed;
    endcase
  end

  assign tick = timer_tick_enable;
  assign at_top = tick & (counter_value == top_val);
  assign at_bot = tick & (counter_value == `TMR_BOTTOM);
  assign at_max = tick & (counter_value == `TMR_MAX);

  always @*
  begin
    case (upd_at)
      `TMR_EVT_TOP: upd_evt = at_top;
      `TMR_EVT_BOT: upd_evt = at_bot;
      default: upd_evt = 1'b1;
    endcase
    case (ovf_at)
      `TMR_EVT_TOP: ovf_evt = at_top;
      `TMR_EVT_BOT: ovf_evt = at_bot;
      default: ovf_evt = at_max;
    endcase
  end

  assign reload = upd_evt;
  assign overflow_flag_set = ovf_evt;
  assign cnt_load = wr_en & (avs_address == `TMR_REG_COUNT);

  tmr_count u_count (
    .clock(clock),
    .rst_b(rst_b),
    .tick(tick),
    .dual(cls == `TMR_CLS_DUAL),
    .top(top_val),
    .load(cnt_load),
    .load_val(avs_writedata[15:0]),
    .count_r(counter_value),
    .down_r(count_down)
  );

  tmr_ocu u_ocu_a (
    .clock(clock),
    .rst_b(rst_b),
    .buf_val(cmp_buf_a_r),
    .load(reload),
    .tick(tick),
    .count(counter_value),
    .top(top_val),
    .down(count_down),
    .wrap(counter_value == top_val),
    .cls(cls),
    .action(chan_a_output_action),
    .toggle_ok(toggle_ok),
    .ocr_r(compare_value_a),
    .match(match_a),
    .wave_r(wave_out_a),
    .wave_on(wave_on_a)
  );

  // Channel B never gets the toggle permission
  tmr_ocu u_ocu_b (
    .clock(clock),
    .rst_b(rst_b),
    .buf_val(cmp_buf_b_r),
    .load(reload),
    .tick(tick),
    .count(counter_value),
    .top(top_val),
    .down(count_down),
    .wrap(counter_value == top_val),
    .cls(cls),
    .action(chan_b_output_action),
    .toggle_ok(1'b0),
    .ocr_r(compare_value_b),
    .match(match_b),
    .wave_r(wave_out_b),
    .wave_on(wave_on_b)
  );

  // Sticky flags: a new event beats a same-cycle write-one-to-clear
  assign irq_set = {match_b, match_a, overflow_flag_set};
  assign irq_clr = (wr_en & (avs_address == `TMR_REG_IRQ_STAT)) ? avs_writedata[2:0] : `TMR_RST_IRQ;

  always @*
  begin
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timer_control_a_r <= `TMR_RST8;
      timer_control_b_r <= `TMR_RST8;
      cmp_buf_a_r <= `TMR_RST16;
      cmp_buf_b_r <= `TMR_RST16;
      capture_value_r <= `TMR_RST16;
      port_r <= `TMR_RST_PORT;
      irq_stat_r <= `TMR_RST_IRQ;
      irq_mask_r <= `TMR_RST_IRQ;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_en)
      begin
        case (avs_address)
          `TMR_REG_CTRL_A: timer_control_a_r <= avs_writedata[7:0];
          `TMR_REG_CTRL_B: timer_control_b_r <= avs_writedata[7:0] & `TMR_CB_MASK;
          `TMR_REG_CMP_A: cmp_buf_a_r <= avs_writedata[15:0];
          `TMR_REG_CMP_B: cmp_buf_b_r <= avs_writedata[15:0];
          `TMR_REG_CAPT: capture_value_r <= avs_writedata[15:0];
          `TMR_REG_PORT: port_r <= avs_writedata[3:0];
          `TMR_REG_IRQ_MASK: irq_mask_r <= avs_writedata[2:0];
          default: port_r <= port_r;
        endcase
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rd_nxt = `TMR_RST32;
    case (avs_address)
      `TMR_REG_CTRL_A: rd_nxt[7:0] = timer_control_a_r;
      `TMR_REG_CTRL_B: rd_nxt[7:0] = timer_control_b_r;
      `TMR_REG_COUNT: rd_nxt[15:0] = counter_value;
      `TMR_REG_CMP_A: rd_nxt[15:0] = cmp_buf_a_r;
      `TMR_REG_CMP_B: rd_nxt[15:0] = cmp_buf_b_r;
      `TMR_REG_CAPT: rd_nxt[15:0] = capture_value_r;
      `TMR_REG_PORT: rd_nxt[3:0] = port_r;
      `TMR_REG_IRQ_STAT: rd_nxt[2:0] = irq_stat_r;
      `TMR_REG_IRQ_MASK: rd_nxt[2:0] = irq_mask_r;
      default: rd_nxt = `TMR_RST32;
    endcase
  end

  // Pin drive, registered so every output comes from a flop
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_a_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      pin_a_out <= wave_on_a ? wave_out_a : port_r[`TMR_PORT_DATA_A];
      pin_b_out <= wave_on_b ? wave_out_b : port_r[`TMR_PORT_DATA_B];
      pin_a_oe <= port_r[`TMR_PORT_DIR_A];
      pin_b_oe <= port_r[`TMR_PORT_DIR_B];
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

endmodule // tmr_wave_ctrl

// [hw/tmr_consts.vh]
// Function
// - Counter synchronous, tick is clock enable
// - Phase-frequency correct reloads compare at BOTTOM
// - Nonzero channel A action overrides pin A, except code 01 in PWM modes other than 9/11/14/15
// - Nonzero channel B action overrides pin B, except code 01 in any PWM mode
// - Pin driven only when direction is output
// - Non-PWM codes: off, toggle, clear, set
// - Fast PWM: 10 non-inverting, 11 inverting
// - Fast PWM code 01 toggles A in 14/15
// - Fast PWM 10/11: match at TOP ignored, BOTTOM acts
// - Dual-slope: 10 clear up, set down; 11 opposite
// - Dual-slope code 01 toggles A in 9/11
// - Mode from control A 1:0, control B bits
// - Modes 1-3,10,11: reload TOP, overflow BOTTOM
// - Modes 8,9: reload BOTTOM, overflow BOTTOM
// - Fast modes: reload BOTTOM, overflow TOP
// - Modes 0,4,12: immediate reload, overflow MAX
// - Dual-slope counts BOTTOM to TOP and back
// - Phase-frequency correct holds TOP one tick
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// Register byte offsets
`define TMR_REG_CTRL_A 6'h00
`define TMR_REG_CTRL_B 6'h04
`define TMR_REG_COUNT 6'h08
`define TMR_REG_CMP_A 6'h0c
`define TMR_REG_CMP_B 6'h10
`define TMR_REG_CAPT 6'h14
`define TMR_REG_PORT 6'h18
`define TMR_REG_IRQ_STAT 6'h1c
`define TMR_REG_IRQ_MASK 6'h20

// Control A fields
`define TMR_CA_ACT_A_HI 7
`define TMR_CA_ACT_A_LO 6
`define TMR_CA_ACT_B_HI 5
`define TMR_CA_ACT_B_LO 4
`define TMR_CA_MODE_HI 1
`define TMR_CA_MODE_LO 0
// Control B fields
`define TMR_CB_MODE_HI 4
`define TMR_CB_MODE_LO 3
`define TMR_CB_CS_HI 2
`define TMR_CB_CS_LO 0
`define TMR_CB_MASK 8'h1f
// Port register fields
`define TMR_PORT_DIR_A 0
`define TMR_PORT_DIR_B 1
`define TMR_PORT_DATA_A 2
`define TMR_PORT_DATA_B 3
// Interrupt status and mask fields
`define TMR_IRQ_OVF 0
`define TMR_IRQ_MATCH_A 1
`define TMR_IRQ_MATCH_B 2

// Reset values
`define TMR_RST8 8'h00
`define TMR_RST16 16'h0000
`define TMR_RST_PORT 4'h0
`define TMR_RST_IRQ 3'h0
`define TMR_RST32 32'h00000000

// Waveform classes
`define TMR_CLS_NORM 2'h0
`define TMR_CLS_FAST 2'h1
`define TMR_CLS_DUAL 2'h2

// Output action codes
`define TMR_ACT_OFF 2'h0
`define TMR_ACT_TOG 2'h1
`define TMR_ACT_CLR 2'h2
`define TMR_ACT_SET 2'h3

// Event points for compare reload and overflow
`define TMR_EVT_IMM 2'h0
`define TMR_EVT_TOP 2'h1
`define TMR_EVT_BOT 2'h2

// TOP sources
`define TMR_TOP_FIX 2'h0
`define TMR_TOP_CMPA 2'h1
`define TMR_TOP_CAPT 2'h2

// Counter values
`define TMR_BOTTOM 16'h0000
`define TMR_ONE 16'h0001
`define TMR_MAX 16'hffff
`define TMR_TOP_8 16'h00ff
`define TMR_TOP_9 16'h01ff
`define TMR_TOP_10 16'h03ff

// Mode numbers
`define TMR_MODE_0 4'h0
`define TMR_MODE_1 4'h1
`define TMR_MODE_2 4'h2
`define TMR_MODE_3 4'h3
`define TMR_MODE_4 4'h4
`define TMR_MODE_5 4'h5
`define TMR_MODE_6 4'h6
`define TMR_MODE_7 4'h7
`define TMR_MODE_8 4'h8
`define TMR_MODE_9 4'h9
`define TMR_MODE_10 4'ha
`define TMR_MODE_11 4'hb
`define TMR_MODE_12 4'hc
`define TMR_MODE_13 4'hd
`define TMR_MODE_14 4'he
`define TMR_MODE_15 4'hf

`endif

// [hw/tmr_count.v]
`timescale 1ns/10ps
`include "tmr_consts.vh"

module tmr_count (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Control
  input wire tick,
  input wire dual,
  input wire [15:0] top,
  // Software load
  input wire load,
  input wire [15:0] load_val,
  // State
  output reg [15:0] count_r,
  output reg down_r
);

  reg [15:0] count_nxt;
  reg down_nxt;

  always @*
  begin
    count_nxt = count_r;
    down_nxt = down_r;
    if (load)
    begin
      count_nxt = load_val;
    end
    else if (tick)
    begin
      if (dual)
      begin
        // Counter sits at TOP for the tick that reverses it
        if (!down_r)
        begin
          if (count_r >= top)
          begin
            down_nxt = (top != `TMR_BOTTOM);
            count_nxt = (top == `TMR_BOTTOM) ? `TMR_BOTTOM : count_r - `TMR_ONE;
          end
          else
          begin
            count_nxt = count_r + `TMR_ONE;
          end
        end
        else if (count_r == `TMR_BOTTOM)
        begin
          down_nxt = 1'b0;
          count_nxt = `TMR_ONE;
        end
        else
        begin
          count_nxt = count_r - `TMR_ONE;
        end
      end
      else
      begin
        // Equality only: a TOP lowered under the count runs on to MAX
        down_nxt = 1'b0;
        count_nxt = (count_r == top) ? `TMR_BOTTOM : count_r + `TMR_ONE;
      end
    end
    if (!dual)
    begin
      down_nxt = 1'b0;
    end
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_r <= `TMR_RST16;
      down_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      down_r <= down_nxt;
    end
  end

endmodule // tmr_count

// [hw/tmr_ocu.v]
`timescale 1ns/10ps
`include "tmr_consts.vh"

module tmr_ocu (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Compare buffer and reload strobe
  input wire [15:0] buf_val,
  input wire load,
  // Counter state
  input wire tick,
  input wire [15:0] count,
  input wire [15:0] top,
  input wire down,
  input wire wrap,
  // Configuration
  input wire [1:0] cls,
  input wire [1:0] action,
  input wire toggle_ok,
  // Results
  output reg [15:0] ocr_r,
  output wire match,
  output reg wave_r,
  output wire wave_on
);

  reg wave_nxt;

  assign match = tick & (count == ocr_r);

  // Toggle code outside non-PWM needs the per-mode permission
  assign wave_on = (action != `TMR_ACT_OFF) &
    ~((action == `TMR_ACT_TOG) & (cls != `TMR_CLS_NORM) & ~toggle_ok);

  always @*
  begin
    wave_nxt = wave_r;
    case (cls)
      `TMR_CLS_NORM:
      begin
        if (match)
        begin
          case (action)
            `TMR_ACT_TOG: wave_nxt = ~wave_r;
            `TMR_ACT_CLR: wave_nxt = 1'b0;
            `TMR_ACT_SET: wave_nxt = 1'b1;
            default: wave_nxt = wave_r;
          endcase
        end
      end
      `TMR_CLS_FAST:
      begin
        if (action[1])
        begin
          // Wrap wins, so a match at TOP is dropped
          if (tick & wrap)
            wave_nxt = ~action[0];
          else if (match & (ocr_r != top))
            wave_nxt = action[0];
        end
        else if ((action == `TMR_ACT_TOG) & toggle_ok & match)
        begin
          wave_nxt = ~wave_r;
        end
      end
      `TMR_CLS_DUAL:
      begin
        if (action[1] & match)
          wave_nxt = down ? ~action[0] : action[0];
        else if ((action == `TMR_ACT_TOG) & toggle_ok & match)
          wave_nxt = ~wave_r;
      end
      default: wave_nxt = wave_r;
    endcase
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ocr_r <= `TMR_RST16;
      wave_r <= 1'b0;
    end
    else
    begin
      if (load)
        ocr_r <= buf_val;
      wave_r <= wave_nxt;
    end
  end

endmodule // tmr_ocu

// [verif/tmr_pin_load.sv]
`timescale 1ns/10ps
module tmr_pin_load (
  // Driven side of the two pins
  input wire pin_a_out,
  input wire pin_a_oe,
  input wire pin_b_out,
  input wire pin_b_oe,
  // Levels seen on the board
  output wire line_a,
  output wire line_b
);
  // Board pull-downs: an undriven pin reads low, never a stale level
  assign line_a = pin_a_oe ? pin_a_out : 1'b0;
  assign line_b = pin_b_oe ? pin_b_out : 1'b0;
endmodule // tmr_pin_load

// [verif/tmr_wave_ctrl_monitor.sv]
`timescale 1ns/10ps
module tmr_wave_ctrl_monitor (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Register bus
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Timer and pins
  input wire timer_tick_enable,
  input wire pin_a_out,
  input wire pin_a_oe,
  input wire pin_b_out,
  input wire pin_b_oe,
  input wire irq
);
  default clocking mcb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  wire wr_ok = avs_write && !avs_waitrequest;
  sequence req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_low;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // Six idle cycles cover the event, status and pin register stages
  sequence quiet;
    (!timer_tick_enable && !avs_write)[*6];
  endsequence
  req_answer_a: assert property (req_taken |=> one_low)
    else $error("bus request not answered in one cycle");
  idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("wait low without request");
  rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  pin_quiet_a: assert property (quiet |-> $stable(pin_a_out) && $stable(pin_b_out))
    else $error("pin moved without tick");
  irq_quiet_a: assert property (quiet |-> $stable(irq))
    else $error("irq moved without tick");
  oe_a_cause_a: assert property (!$stable(pin_a_oe) |-> $past(wr_ok) || $past(wr_ok, 2) || $past(wr_ok, 3))
    else $error("pin a enable moved without write");
  oe_b_cause_a: assert property (!$stable(pin_b_oe) |-> $past(wr_ok) || $past(wr_ok, 2) || $past(wr_ok, 3))
    else $error("pin b enable moved without write");
  // Event in the cycle before the rise, or a mask write two cycles before it
  irq_cause_a: assert property ($rose(irq) |-> $past(timer_tick_enable) || $past(wr_ok, 2))
    else $error("irq rose without event or write");
endmodule // tmr_wave_ctrl_monitor
bind tmr_wave_ctrl tmr_wave_ctrl_monitor mon (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer_tick_enable(timer_tick_enable), .pin_a_out(pin_a_out),
  .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .irq(irq));

// [verif/testbench.sv]
`timescale 1ns/10ps
`include "tmr_consts.vh"
module testbench;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg [5:0] avs_address = 6'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg timer_tick_enable = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, irq, line_a, line_b;
  integer num_errors = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer ha, hb;
  reg [31:0] rd;
  tmr_wave_ctrl dut (.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_tick_enable(timer_tick_enable), .pin_a_out(pin_a_out),
    .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .irq(irq));
  tmr_pin_load load (.pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
    .pin_b_oe(pin_b_oe), .line_a(line_a), .line_b(line_b));
  initial forever #20 clock = ~clock;
  task final_report;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  task check(input string what, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("BAD %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Holds the request until an edge samples waitrequest low; data is taken and the request dropped there
  task bus(input wr, input [5:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0 && n < 100)
      begin
        @(posedge clock);
        n = n + 1;
      end
      check("bus answer", 32'h0, n / 100);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input [5:0] a, input [31:0] exp, input string what);
    begin
      bus(1'b0, a, 32'h0);
      check(what, exp, rd);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask
  task pulse;
    begin
      @(posedge clock);
      timer_tick_enable <= 1'b1;
      @(posedge clock);
      timer_tick_enable <= 1'b0;
    end
  endtask
  task t_regs;
    begin
      rdc(`TMR_REG_CTRL_A, 32'h0, "ctrl_a reset");
      rdc(`TMR_REG_PORT, 32'h0, "port reset");
      wr(`TMR_REG_CTRL_B, 32'hff);
      rdc(`TMR_REG_CTRL_B, 32'h1f, "ctrl_b bits");
      wr(6'h24, 32'h5a);
      rdc(6'h24, 32'h0, "unmapped");
      wr(`TMR_REG_CMP_A, 32'h1234_5678);
      rdc(`TMR_REG_CMP_A, 32'h5678, "cmp_a");
      wr(`TMR_REG_CTRL_B, 32'h0);
    end
  endtask
  task t_port;
    begin
      wr(`TMR_REG_PORT, 32'hd);
      cyc(3);
      check("pin a port", 32'h1, line_a);
      check("oe b", 32'h0, pin_b_oe);
      check("pin b off", 32'h0, line_b);
      wr(`TMR_REG_PORT, 32'hf);
      cyc(3);
      check("pin b port", 32'h1, line_b);
    end
  endtask
  // Count is written last so that a stale count above the new TOP never runs to the wrap
  task run(input [7:0] cb, ca, input [15:0] capt, cmpa, cmpb, input [3:0] port, input integer ea, eb);
    begin
      wr(`TMR_REG_CTRL_B, cb);
      wr(`TMR_REG_CAPT, capt);
      wr(`TMR_REG_CMP_A, cmpa);
      wr(`TMR_REG_CMP_B, cmpb);
      wr(`TMR_REG_PORT, port);
      wr(`TMR_REG_CTRL_A, ca);
      wr(`TMR_REG_COUNT, 32'h0);
      cyc(30);
      ha = 0;
      hb = 0;
      repeat (40)
      begin
        @(negedge clock);
        ha = ha + line_a;
        hb = hb + line_b;
      end
      check("high a", ea, ha);
      check("high b", eb, hb);
    end
  endtask
  task ovf(input [7:0] cb, ca, input [15:0] start, input exp);
    begin
      @(posedge clock);
      timer_tick_enable <= 1'b0;
      wr(`TMR_REG_CTRL_B, cb);
      wr(`TMR_REG_CTRL_A, ca);
      wr(`TMR_REG_CAPT, 32'h9);
      wr(`TMR_REG_COUNT, start);
      wr(`TMR_REG_IRQ_STAT, 32'h7);
      pulse;
      bus(1'b0, `TMR_REG_IRQ_STAT, 32'h0);
      check("ovf early", 32'h0, rd[0]);
      pulse;
      bus(1'b0, `TMR_REG_IRQ_STAT, 32'h0);
      check("ovf", exp, rd[0]);
      cyc(5);
      rdc(`TMR_REG_COUNT, 32'h0, "count held");
    end
  endtask
  task t_irq;
    begin
      cyc(1);
      check("irq masked", 32'h0, irq);
      wr(`TMR_REG_IRQ_MASK, 32'h1);
      cyc(3);
      check("irq on", 32'h1, irq);
      wr(`TMR_REG_IRQ_STAT, 32'h1);
      cyc(3);
      check("irq cleared", 32'h0, irq);
      bus(1'b0, `TMR_REG_IRQ_STAT, 32'h0);
      check("status cleared", 32'h0, rd[0]);
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    t_regs;
    t_port;
    @(posedge clock);
    timer_tick_enable <= 1'b1;
    run(8'h08, 8'h70, 16'h0, 16'h4, 16'h2, 4'h3, 20, 40);
    run(8'h08, 8'h60, 16'h0, 16'h4, 16'h2, 4'h3, 20, 0);
    run(8'h18, 8'hb2, 16'h9, 16'h3, 16'h3, 4'h3, 16, 24);
    run(8'h18, 8'ha2, 16'h9, 16'h3, 16'h9, 4'h3, 16, 40);
    run(8'h18, 8'h52, 16'h9, 16'h3, 16'h3, 4'h3, 20, 0);
    run(8'h18, 8'h53, 16'h9, 16'h3, 16'h3, 4'h3, 20, 0);
    run(8'h08, 8'h51, 16'h9, 16'h3, 16'h3, 4'hf, 40, 40);
    run(8'h10, 8'hb0, 16'h5, 16'h2, 16'h2, 4'h3, 16, 24);
    run(8'h10, 8'h51, 16'h5, 16'h5, 16'h2, 4'h3, 20, 0);
    run(8'h10, 8'h53, 16'h5, 16'h5, 16'h2, 4'h3, 20, 0);
    run(8'h10, 8'h52, 16'h5, 16'h5, 16'h2, 4'hf, 40, 40);
    ovf(8'h18, 8'h02, 16'h8, 1'b1);
    ovf(8'h18, 8'h00, 16'h8, 1'b0);
    ovf(8'h00, 8'h00, 16'hfffe, 1'b1);
    ovf(8'h08, 8'h03, 16'h3fe, 1'b1);
    ovf(8'h18, 8'h01, 16'hfffe, 1'b1);
    t_irq;
    final_report;
  end
endmodule // testbench
